// ==== hw/i2f_flags.sv ====
// direction, ack-detected and start-detected flags with ahb-lite register access
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`include "i2f_defs.svh"

// Notes on behaviour
// - direction flag 0 means receive; data line output released.
// - direction flag 1 drives output latch, from falling edge of ninth clock.
// - as master, generating a start sets the direction flag.
// - as slave, first-byte direction bit 1 sets the direction flag.
// - stop, release, wait-release, enable fall, arbitration loss, reset clear direction.
// - as master, sending direction bit 1 clears the direction flag.
// - as slave, start, direction bit 0, or idle clear the direction flag.
// - data low at rising edge of ninth clock sets ack-detected flag.
// - stop, next byte first clock, release, enable fall, reset clear ack flag.
// - detected start sets start flag; it marks the address phase.
// - stop, first clock after address byte, release, enable fall, reset clear start.
// - wait-release at ninth clock with direction 1 clears it, releases data.
// - release is control bit 6, enable is control bit 7.
module i2f_flags (
  input wire logic hclk,             // system clock
  input wire logic hresetn,          // async reset, active low
  input wire logic hsel,             // slave select
  input wire logic [11:0] haddr,     // byte address
  input wire logic [1:0] htrans,     // transfer type
  input wire logic hwrite,           // write strobe
  input wire logic [2:0] hsize,      // transfer size
  input wire logic [31:0] hwdata,    // write data
  input wire logic hready,           // bus ready in
  output logic [31:0] hrdata,        // read data
  output logic hreadyout,            // always ready
  output logic hresp,                // always okay
  input wire logic scl_in,           // clock line level
  input wire logic sda_in,           // data line level
  input wire logic sout_bit,         // serial output latch bit to drive
  output logic sda_oe,               // high while pulling data line
  output logic sda_out,              // data line drive value
  output logic irq                   // level interrupt
);
  typedef struct packed {
    logic ap_valid;
    logic ap_write;
    logic [11:0] ap_addr;
    logic [31:0] rdata;
    logic [7:0] control;
    logic [7:0] events;
    logic [7:0] mask;
    logic master;
    logic dir;
    logic ack;
    logic start;
    logic drive_en;
    logic [3:0] bit_cnt;
    logic first_byte;
    i2f_pkg::i2f_phase_t phase;
    logic sda_oe;
    logic sda_out;
    logic irq;
  } i2f_state_t;

  i2f_state_t st;
  i2f_state_t next_st;

  logic scl_lvl, scl_rise, scl_fall;
  logic sda_lvl, sda_rise, sda_fall;

  i2f_sync u_scl (
    .hclk(hclk),
    .hresetn(hresetn),
    .line_in(scl_in),
    .level(scl_lvl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  i2f_sync u_sda (
    .hclk(hclk),
    .hresetn(hresetn),
    .line_in(sda_in),
    .level(sda_lvl),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ofs);
    is_addr = (a == ofs);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic start_det, stop_det, ninth_rise, ninth_fall, first_rise, lsb_rise;
  logic wr_ctl, wr_evt, wr_mask, wr_cmd, en_fall, rel_cmd, wrel_cmd;
  logic gen_start, arb_loss;
  logic [7:0] ev_set;
  logic [7:0] new_ctl;

  always_comb begin
    next_st = st;
    start_det = scl_lvl & sda_fall;
    stop_det = scl_lvl & sda_rise;
    first_rise = scl_rise & (st.bit_cnt == 4'h0) & (st.phase != i2f_pkg::I2F_IDLE);
    lsb_rise = scl_rise & (st.bit_cnt == 4'h7) & st.first_byte;
    ninth_rise = scl_rise & (st.bit_cnt == 4'h8);
    ninth_fall = scl_fall & (st.bit_cnt == 4'h9);
    wr_ctl = st.ap_valid & st.ap_write & is_addr(st.ap_addr, `I2F_OFS_CONTROL);
    wr_evt = st.ap_valid & st.ap_write & is_addr(st.ap_addr, `I2F_OFS_EVENTS);
    wr_mask = st.ap_valid & st.ap_write & is_addr(st.ap_addr, `I2F_OFS_MASK);
    wr_cmd = st.ap_valid & st.ap_write & is_addr(st.ap_addr, `I2F_OFS_CMD);
    new_ctl = hwdata[7:0];
    // release and wait-release are one-shot commands; they never stay stored
    rel_cmd = wr_ctl & new_ctl[`I2F_CTL_RELEASE];
    wrel_cmd = wr_ctl & new_ctl[`I2F_CTL_WAIT_REL];
    en_fall = wr_ctl & st.control[`I2F_CTL_ENABLE] & ~new_ctl[`I2F_CTL_ENABLE];
    gen_start = wr_cmd & hwdata[`I2F_CMD_START];
    arb_loss = wr_cmd & hwdata[`I2F_CMD_ARBLOSS];

    // bus activity tracking
    if (start_det) begin
      next_st.bit_cnt = 4'h0;
      next_st.first_byte = 1'b1;
      next_st.phase = i2f_pkg::I2F_ADDR;
    end else if (stop_det) begin
      next_st.phase = i2f_pkg::I2F_IDLE;
      next_st.bit_cnt = 4'h0;
    end else if (st.phase != i2f_pkg::I2F_IDLE) begin
      if (scl_rise && st.bit_cnt < 4'h9) begin
        next_st.bit_cnt = st.bit_cnt + 4'h1;
      end
      if (ninth_fall) begin
        next_st.bit_cnt = 4'h0;
        next_st.first_byte = 1'b0;
        next_st.phase = i2f_pkg::I2F_DATA;
      end
    end

    if (wr_ctl) begin
      next_st.control = new_ctl & 8'h81;
      next_st.master = new_ctl[`I2F_CTL_MASTER];
    end

    // direction flag: clears win over sets within one cycle, except a master start command beats the master's direction-bit clear
    if (lsb_rise) begin
      if (st.master) begin
        next_st.dir = ~sout_bit;
      end else begin
        next_st.dir = sda_lvl;
      end
    end
    if (gen_start && st.master) begin
      next_st.dir = 1'b1;
    end
    if (start_det && !st.master) begin
      next_st.dir = 1'b0;
    end
    if (!st.control[`I2F_CTL_ENABLE] || (!st.master && st.phase == i2f_pkg::I2F_IDLE && !gen_start)) begin
      next_st.dir = 1'b0;
    end
    if (stop_det || rel_cmd || wrel_cmd || en_fall || arb_loss) begin
      next_st.dir = 1'b0;
    end

    // drive the latch only once a ninth clock has fallen with the direction flag set
    if (ninth_fall && st.dir) begin
      next_st.drive_en = 1'b1;
    end
    if (!next_st.dir) begin
      next_st.drive_en = 1'b0;
    end
    next_st.sda_oe = next_st.drive_en & ~sout_bit;
    next_st.sda_out = 1'b0;

    if (ninth_rise && !sda_lvl) begin
      next_st.ack = 1'b1;
    end
    if (stop_det || first_rise || rel_cmd || en_fall) begin
      next_st.ack = 1'b0;
    end

    if (first_rise && st.phase == i2f_pkg::I2F_DATA) begin
      next_st.start = 1'b0;
    end
    if (start_det) begin
      next_st.start = 1'b1;
    end
    if (stop_det || rel_cmd || en_fall) begin
      next_st.start = 1'b0;
    end

    // events: hardware set wins over write-one-to-clear
    ev_set = {4'h0, ~st.dir & next_st.dir, ~st.ack & next_st.ack, start_det, stop_det};
    if (wr_evt) begin
      next_st.events = st.events & ~new_ctl;
    end
    next_st.events = next_st.events | ev_set;
    if (wr_mask) begin
      next_st.mask = new_ctl & 8'h0f;
    end
    next_st.irq = |(next_st.events & next_st.mask);

    // ---------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ---------------------------------------------------------------
    next_st.ap_valid = hsel & hready & htrans[1];
    next_st.ap_write = hwrite;
    next_st.ap_addr = haddr;
    next_st.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (is_addr(haddr, `I2F_OFS_CONTROL)) begin
        next_st.rdata = {24'h00_0000, st.control};
      end else if (is_addr(haddr, `I2F_OFS_STATUS)) begin
        // plain read, no flag is disturbed
        next_st.rdata = {28'h000_0000, st.dir, st.ack, st.start, 1'b0};
      end else if (is_addr(haddr, `I2F_OFS_EVENTS)) begin
        next_st.rdata = {24'h00_0000, st.events};
      end else if (is_addr(haddr, `I2F_OFS_MASK)) begin
        next_st.rdata = {24'h00_0000, st.mask};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.control <= `I2F_CTL_RESET;
      st.mask <= `I2F_MASK_RESET;
      st.phase <= i2f_pkg::I2F_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sda_oe = st.sda_oe;
  assign sda_out = st.sda_out;
  assign irq = st.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_recv_release: assert property (@(posedge hclk) disable iff (!hresetn)
    !st.dir |=> !st.sda_oe) else $error("data line driven in receive status");
  a_drive_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st.drive_en) |-> $past(ninth_fall)) else $error("drive began before ninth fall");
  a_master_start: assert property (@(posedge hclk) disable iff (!hresetn)
    gen_start && st.master && !arb_loss && !rel_cmd && !wrel_cmd && !en_fall && !stop_det
    && st.control[`I2F_CTL_ENABLE] |=> st.dir) else $error("start did not set direction");
  a_stop_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_det |=> !st.dir && !st.ack && !st.start) else $error("stop left a flag set");
  a_ack_set: assert property (@(posedge hclk) disable iff (!hresetn)
    ninth_rise && !sda_lvl && !stop_det && !rel_cmd && !en_fall |=> st.ack)
    else $error("ack not caught");
  a_ack_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    first_rise |=> !st.ack) else $error("ack kept past next byte");
  a_start_set: assert property (@(posedge hclk) disable iff (!hresetn)
    start_det && !stop_det && !rel_cmd && !en_fall |=> st.start) else $error("start not flagged");
  a_release_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    rel_cmd || en_fall |=> !st.start ##1 !st.sda_oe) else $error("release left start set");
  a_wait_release: assert property (@(posedge hclk) disable iff (!hresetn)
    wrel_cmd |=> !st.dir ##1 !st.sda_oe) else $error("wait-release kept drive");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    st.irq == |(st.events & st.mask)) else $error("irq disagrees with events");
endmodule

// ==== hw/i2f_defs.svh ====
// register offsets, field positions and reset values for the i2c status flags block
`ifndef I2F_DEFS_SVH
`define I2F_DEFS_SVH
`define I2F_OFS_CONTROL 12'h000
`define I2F_OFS_STATUS 12'h004
`define I2F_OFS_EVENTS 12'h008
`define I2F_OFS_MASK 12'h00c
`define I2F_OFS_CMD 12'h010
`define I2F_CTL_ENABLE 7
`define I2F_CTL_RELEASE 6
`define I2F_CTL_WAIT_REL 5
`define I2F_CTL_MASTER 0
`define I2F_ST_DIR 3
`define I2F_ST_ACK 2
`define I2F_ST_START 1
`define I2F_ST_STOP 0
`define I2F_CMD_START 0
`define I2F_CMD_ARBLOSS 1
`define I2F_CTL_RESET 8'h00
`define I2F_MASK_RESET 8'h00
`endif

// ==== hw/i2f_pkg.sv ====
// types shared by the i2c status flags block
package i2f_pkg;
  typedef enum logic [1:0] {
    I2F_IDLE,
    I2F_ADDR,
    I2F_DATA
  } i2f_phase_t;
endpackage

// ==== hw/i2f_sync.sv ====
// two-flop synchroniser and edge finder for the bus lines
module i2f_sync (
  input wire logic hclk,      // system clock
  input wire logic hresetn,   // async reset, active low
  input wire logic line_in,   // raw bus line
  output logic level,         // synchronised level
  output logic rise,          // one-cycle pulse on rising edge
  output logic fall           // one-cycle pulse on falling edge
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } i2f_sync_state_t;

  i2f_sync_state_t st;
  i2f_sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = line_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= 3'b111;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.s2;
  assign rise = st.s2 & ~st.s3;
  assign fall = ~st.s2 & st.s3;
endmodule

// ==== tb/i2f_bus_model.sv ====
// bus partner model: another party driving the clock and data lines
module i2f_bus_model (
  output logic scl_line, // clock line, idle high, still outside frames
  output logic sda_low   // high while this party pulls the data line low
);
  timeunit 1ns;
  timeprecision 10ps;
  initial begin
    scl_line = 1'b1;
    sda_low = 1'b0;
  end
  // data only changes while the clock is low, except in start and stop
  task automatic bit_out(input logic b);
    sda_low = ~b;
    #31.25;
    scl_line = 1'b1;
    #62.5;
    scl_line = 1'b0;
    #31.25;
  endtask
  // also serves as repeated start: line is raised first
  task automatic start_cond();
    sda_low = 1'b0;
    #31.25;
    scl_line = 1'b1;
    #31.25;
    sda_low = 1'b1;
    #62.5;
    scl_line = 1'b0;
    #31.25;
  endtask
  task automatic send_byte(input logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_out(~ack);
    sda_low = 1'b0;
  endtask
  task automatic stop_cond();
    sda_low = 1'b1;
    #31.25;
    scl_line = 1'b1;
    #31.25;
    sda_low = 1'b0;
    #62.5;
  endtask
endmodule

// ==== tb/test_i2c_direction_ack_start_flags.sv ====
// self-checking testbench for the i2c status flags block
`include "i2f_defs.svh"
module test_i2c_direction_ack_start_flags;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] EN = 32'h1 << `I2F_CTL_ENABLE;
  localparam logic [31:0] REL = 32'h1 << `I2F_CTL_RELEASE;
  localparam logic [31:0] WREL = 32'h1 << `I2F_CTL_WAIT_REL;
  localparam logic [31:0] MST = 32'h1 << `I2F_CTL_MASTER;
  localparam logic [31:0] GO = 32'h1 << `I2F_CMD_START;
  localparam logic [31:0] ACKB = 32'h1 << `I2F_ST_ACK;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sout_bit = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sda_oe, sda_out, irq, scl_line, sda_low;
  // open drain with pull-up: low when any party pulls
  wire logic sda_line = ~(sda_low | sda_oe);
  int err_total = 0;
  int checks_done = 0;
  always #2 hclk = ~hclk;
  i2f_flags i2f_flags_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_line), .sda_in(sda_line), .sout_bit(sout_bit),
    .sda_oe(sda_oe), .sda_out(sda_out), .irq(irq));
  i2f_bus_model i2f_bus_model_i (.scl_line(scl_line), .sda_low(sda_low));
  // ----------------------------------------
  // reporting and bus access
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        err_total++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  // stop flag is outside this block's scope, so bit 0 is masked
  task automatic stat(input logic d, input logic a, input logic s);
    logic [31:0] x;
    bus(1'b0, `I2F_OFS_STATUS, 32'h0, x);
    chk("bus_status", x & ~(32'h1 << `I2F_ST_STOP),
      (32'(d) << `I2F_ST_DIR) | (32'(a) << `I2F_ST_ACK) | (32'(s) << `I2F_ST_START));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] x;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    stat(0, 0, 0);
    bus(1'b0, 12'h0f0, 32'h0, x);
    chk("unmapped", x, 32'h0);
    chk("hresp", 32'(hresp), 32'h0);
    wr(`I2F_OFS_STATUS, 32'hf);
    stat(0, 0, 0);
    wr(`I2F_OFS_MASK, ACKB);
    bus(1'b0, `I2F_OFS_MASK, 32'h0, x);
    chk("mask", x, ACKB);
    wr(`I2F_OFS_CONTROL, EN);
    i2f_bus_model_i.start_cond();
    stat(0, 0, 1);
    chk("irq masked", 32'(irq), 32'h0);
    // only the start-seen event has fired so far
    bus(1'b0, `I2F_OFS_EVENTS, 32'h0, x);
    chk("events", x, 32'h2);
    i2f_bus_model_i.send_byte(8'ha5, 1'b1);
    stat(1, 1, 1);
    chk("sda_oe", 32'(sda_oe), 32'h1);
    chk("sda_out", 32'(sda_out), 32'h0);
    chk("irq", 32'(irq), 32'h1);
    wr(`I2F_OFS_EVENTS, ACKB);
    wr(`I2F_OFS_CONTROL, EN | WREL);
    stat(0, 1, 1);
    chk("sda_oe", 32'(sda_oe), 32'h0);
    // wait-release is one-shot, so only the enable stays stored
    bus(1'b0, `I2F_OFS_CONTROL, 32'h0, x);
    chk("bus_control", x, EN);
    chk("irq cleared", 32'(irq), 32'h0);
    i2f_bus_model_i.send_byte(8'h3c, 1'b0);
    stat(0, 0, 0);
    i2f_bus_model_i.stop_cond();
    i2f_bus_model_i.start_cond();
    i2f_bus_model_i.send_byte(8'ha4, 1'b1);
    stat(0, 1, 1);
    chk("sda_oe", 32'(sda_oe), 32'h0);
    // a latch bit of 1 keeps the line released, so later starts and stops stay visible
    sout_bit <= 1'b1;
    i2f_bus_model_i.start_cond();
    i2f_bus_model_i.send_byte(8'ha5, 1'b1);
    stat(1, 1, 1);
    chk("sda_oe latch one", 32'(sda_oe), 32'h0);
    i2f_bus_model_i.start_cond();
    stat(0, 0, 1);
    i2f_bus_model_i.send_byte(8'ha5, 1'b1);
    stat(1, 1, 1);
    wr(`I2F_OFS_CONTROL, EN | REL);
    stat(0, 0, 0);
    i2f_bus_model_i.start_cond();
    i2f_bus_model_i.send_byte(8'ha5, 1'b1);
    i2f_bus_model_i.stop_cond();
    stat(0, 0, 0);
    wr(`I2F_OFS_CONTROL, EN | MST);
    i2f_bus_model_i.start_cond();
    wr(`I2F_OFS_CMD, GO);
    stat(1, 0, 1);
    @(posedge hclk);
    sout_bit <= 1'b1;
    i2f_bus_model_i.send_byte(8'h00, 1'b1);
    stat(0, 1, 1);
    wr(`I2F_OFS_CMD, GO);
    wr(`I2F_OFS_CMD, 32'h1 << `I2F_CMD_ARBLOSS);
    stat(0, 1, 1);
    wr(`I2F_OFS_CMD, GO);
    wr(`I2F_OFS_CONTROL, 32'h0);
    stat(0, 0, 0);
    i2f_bus_model_i.stop_cond();
    print_verdict();
  end
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule
